// >>> ers_datapath.sv
// Added by the designer: the address-and-strobe port and the register addresses.
`timescale 1ns/10ps
// Function
// RULE1: rotate left through carry: byte up one, carry gets bit 7, old carry to bit 0
// RULE2: rotate forms to accumulator leave memory untouched, result only in accumulator
// RULE3: plain rotate right wraps bit 0 into bit 7, no flag changes
// RULE4: rotate right through carry: carry gets bit 0, old carry into bit 7
// RULE5: subtract with carry is acc minus operand minus inverted carry
// RULE6: subtract without carry puts acc minus operand into accumulator
// RULE7: memory-destination subtracts write the difference back to memory
// RULE8: subtract clears carry on negative result, sets it on zero or positive
// RULE9: subtracts update all six flags; plain rotates, skips, sets touch none
// RULE10: decrement-skip writes byte minus one back, skips when result zero
// RULE11: increment-skip writes byte plus one back, skips when result zero
// RULE12: accumulator forms put adjusted value in acc, memory kept, skip on zero
// RULE13: a taken skip adds one dummy cycle, making the instruction two cycles
// RULE14: byte skip-if-not-zero skips when the addressed byte is nonzero
// RULE15: bit skip-if-not-zero skips when the selected bit is one
// RULE16: set-byte forces all bits of the addressed byte to one
// RULE17: set-bit forces only the selected bit to one, others kept
// RULE18: any data-memory address is reachable directly, no banking
// RULE19: rotate-left-through-carry to acc updates carry like the memory form
module ers_datapath (
    input  wire logic                      i_clk,
    input  wire logic                      i_rst_b,
    input  wire logic                      i_op_valid,
    input  wire ers_pkg::ers_op_e          i_op,
    input  wire logic [ers_pkg::ADDR_W-1:0] i_mem_addr,
    input  wire logic [ers_pkg::DATA_W-1:0] i_mem_data,
    input  wire logic [ers_pkg::BIT_W-1:0]  i_bit_sel,
    input  wire logic [ers_pkg::RADR_W-1:0] i_reg_addr,
    input  wire logic [ers_pkg::DATA_W-1:0] i_reg_wdata,
    input  wire logic                      i_reg_wr,
    input  wire logic                      i_reg_rd,
    output logic [ers_pkg::DATA_W-1:0]     o_reg_rdata,
    output logic                           o_mem_we,
    output logic [ers_pkg::ADDR_W-1:0]     o_mem_addr,
    output logic [ers_pkg::DATA_W-1:0]     o_mem_wdata,
    output logic [ers_pkg::DATA_W-1:0]     o_acc,
    output logic [ers_pkg::ST_W-1:0]       o_status,
    output logic                           o_skip,
    output logic                           o_dummy_cycle
);
    import ers_pkg::*;

    // ****************************************************************
    // operation decode
    // ****************************************************************
    logic              take;
    logic              c_in;
    logic [DATA_W-1:0] bit_mask;
    logic [DATA_W-1:0] next_result;
    logic              next_to_mem;
    logic              next_to_acc;
    logic              next_carry_upd;
    logic              next_carry;
    logic              next_is_sub;
    logic              next_skip;
    logic [DATA_W:0]   sub_full;
    logic [4:0]        sub_low;
    logic              borrow_in;

    // an op arriving during the dummy cycle is ignored
    assign take      = i_op_valid & ~o_dummy_cycle;
    assign c_in      = o_status[ST_CARRY];
    assign bit_mask  = ONE << i_bit_sel;
    // with-carry forms borrow the inverted carry
    assign borrow_in = (i_op == OP_SUBTRACT_BORROW_TO_ACC ||
                        i_op == OP_SUBTRACT_BORROW_TO_MEM) ? ~c_in : 1'b0; // RULE5
    assign sub_full  = {1'b0, o_acc} - {1'b0, i_mem_data} - {8'h00, borrow_in}; // RULE5 RULE6
    assign sub_low   = {1'b0, o_acc[3:0]} - {1'b0, i_mem_data[3:0]} - {4'h0, borrow_in};

    // result, destination and skip for each op
    always_comb begin
        next_result    = i_mem_data;
        next_to_mem    = 1'b0;
        next_to_acc    = 1'b0;
        next_carry_upd = 1'b0;
        next_carry     = c_in;
        next_is_sub    = 1'b0;
        next_skip      = 1'b0;
        unique case (i_op)
            OP_NONE: begin
                next_result = i_mem_data;
            end
            OP_ROTATE_LEFT_THRU_CARRY, OP_ROTATE_LEFT_THRU_CARRY_TO_ACC: begin
                next_result    = {i_mem_data[6:0], c_in}; // RULE1
                next_carry_upd = 1'b1;                    // RULE19
                next_carry     = i_mem_data[7];           // RULE1 RULE19
                next_to_mem    = (i_op == OP_ROTATE_LEFT_THRU_CARRY);
                next_to_acc    = ~next_to_mem;            // RULE2
            end
            OP_ROTATE_RIGHT_BYTE, OP_ROTATE_RIGHT_TO_ACC: begin
                next_result = {i_mem_data[0], i_mem_data[7:1]}; // RULE3
                next_to_mem = (i_op == OP_ROTATE_RIGHT_BYTE);
                next_to_acc = ~next_to_mem;                     // RULE2
            end
            OP_ROTATE_RIGHT_THRU_CARRY, OP_ROTATE_RIGHT_THRU_CARRY_TO_ACC: begin
                next_result    = {c_in, i_mem_data[7:1]}; // RULE4
                next_carry_upd = 1'b1;
                next_carry     = i_mem_data[0];           // RULE4
                next_to_mem    = (i_op == OP_ROTATE_RIGHT_THRU_CARRY);
                next_to_acc    = ~next_to_mem;            // RULE2
            end
            OP_SUBTRACT_BORROW_TO_ACC, OP_SUBTRACT_TO_ACC: begin
                next_result = sub_full[DATA_W-1:0]; // RULE5 RULE6
                next_is_sub = 1'b1;
                next_to_acc = 1'b1;
            end
            OP_SUBTRACT_BORROW_TO_MEM, OP_SUBTRACT_TO_MEM: begin
                next_result = sub_full[DATA_W-1:0];
                next_is_sub = 1'b1;
                next_to_mem = 1'b1; // RULE7
            end
            OP_DECREMENT_SKIP_ZERO, OP_DECREMENT_SKIP_ZERO_TO_ACC: begin
                next_result = i_mem_data - ONE;                        // RULE10
                next_skip   = (next_result == ZERO);                   // RULE10 RULE12
                next_to_mem = (i_op == OP_DECREMENT_SKIP_ZERO);
                next_to_acc = ~next_to_mem;                            // RULE12
            end
            OP_INCREMENT_SKIP_ZERO, OP_INCREMENT_SKIP_ZERO_TO_ACC: begin
                next_result = i_mem_data + ONE;                        // RULE11
                next_skip   = (next_result == ZERO);                   // RULE11 RULE12
                next_to_mem = (i_op == OP_INCREMENT_SKIP_ZERO);
                next_to_acc = ~next_to_mem;                            // RULE12
            end
            OP_SKIP_NONZERO: begin
                next_skip = (i_mem_data != ZERO); // RULE14
            end
            OP_SKIP_NONZERO_BIT: begin
                next_skip = |(i_mem_data & bit_mask); // RULE15
            end
            OP_SET_ALL_BITS: begin
                next_result = ALL_ONES; // RULE16
                next_to_mem = 1'b1;
            end
            OP_SET_BIT: begin
                next_result = i_mem_data | bit_mask; // RULE17
                next_to_mem = 1'b1;
            end
            default: begin
                next_result = i_mem_data;
            end
        endcase
    end

    // ****************************************************************
    // memory write port
    // ****************************************************************
    // one-cycle write pulse with flat address
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_mem_we    <= 1'b0;
            o_mem_addr  <= '0;
            o_mem_wdata <= ZERO;
        end else begin
            o_mem_we <= take & next_to_mem; // RULE7 RULE10 RULE11
            if (take) begin
                o_mem_addr  <= i_mem_addr;  // RULE18
                o_mem_wdata <= next_result;
            end
        end
    end

    // ****************************************************************
    // accumulator
    // ****************************************************************
    // datapath result wins over a register-port write
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_acc <= ACC_RST;
        end else if (take && next_to_acc) begin
            o_acc <= next_result; // RULE2 RULE6 RULE12
        end else if (i_reg_wr && i_reg_addr == REG_ACC) begin
            o_acc <= i_reg_wdata;
        end
    end

    // ****************************************************************
    // status flags
    // ****************************************************************
    // datapath flag updates win over a register-port write
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_status <= STATUS_RST;
        end else if (take && next_is_sub) begin
            o_status[ST_CARRY]           <= ~sub_full[DATA_W]; // RULE8 RULE9
            o_status[ST_NIBBLE_CARRY]    <= ~sub_low[4];       // RULE9
            o_status[ST_ZERO]            <= (sub_full[DATA_W-1:0] == ZERO);
            o_status[ST_SIGNED_WRAP_BIT] <= (o_acc[7] ^ i_mem_data[7]) &
                                            (o_acc[7] ^ sub_full[7]);
            o_status[ST_SIGNED_RESULT]   <= (o_acc[7] ^ i_mem_data[7]) &
                                            (o_acc[7] ^ sub_full[7]) ^ sub_full[7];
            // with-carry forms chain the previous zero state
            o_status[ST_CHAINED_NULL_BIT] <= (sub_full[DATA_W-1:0] == ZERO) &
                (borrow_in || i_op == OP_SUBTRACT_BORROW_TO_ACC ||
                 i_op == OP_SUBTRACT_BORROW_TO_MEM ? o_status[ST_CHAINED_NULL_BIT] : 1'b1);
        end else if (take && next_carry_upd) begin
            o_status[ST_CARRY] <= next_carry; // RULE1 RULE4 RULE19
        end else if (i_reg_wr && i_reg_addr == REG_STATUS) begin
            o_status <= i_reg_wdata[ST_W-1:0];
        end
    end

    // ****************************************************************
    // skip and dummy cycle
    // ****************************************************************
    // skip pulse then one dummy cycle
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_skip        <= 1'b0;
            o_dummy_cycle <= 1'b0;
        end else begin
            o_skip        <= take & next_skip; // RULE13
            o_dummy_cycle <= o_skip;           // RULE13
        end
    end

    // ****************************************************************
    // register read port
    // ****************************************************************
    // read data valid only in the cycle after the strobe
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_reg_rdata <= ZERO;
        end else if (i_reg_rd && i_reg_addr == REG_ACC) begin
            o_reg_rdata <= o_acc;
        end else if (i_reg_rd && i_reg_addr == REG_STATUS) begin
            o_reg_rdata <= {2'b00, o_status};
        end else begin
            o_reg_rdata <= ZERO;
        end
    end

    // ****************************************************************
    // assertions
    // ****************************************************************
    property p_rlc;
        @(posedge i_clk) disable iff (!i_rst_b)
        take && i_op == OP_ROTATE_LEFT_THRU_CARRY |=> o_mem_we &&
            o_mem_wdata == {$past(i_mem_data[6:0]), $past(o_status[ST_CARRY])} &&
            o_status[ST_CARRY] == $past(i_mem_data[7]);
    endproperty
    a_rlc: assert property (p_rlc) else $error("rotate left thru carry wrong"); // RULE1

    property p_acc_rot;
        @(posedge i_clk) disable iff (!i_rst_b)
        take && (i_op == OP_ROTATE_RIGHT_TO_ACC || i_op == OP_ROTATE_LEFT_THRU_CARRY_TO_ACC)
            |=> !o_mem_we && o_acc[6:0] == $past(i_mem_data[7:1]) ||
                !o_mem_we && o_acc[7:1] == $past(i_mem_data[6:0]);
    endproperty
    a_acc_rot: assert property (p_acc_rot) else $error("rotate to acc touched memory"); // RULE2

    property p_rr;
        @(posedge i_clk) disable iff (!i_rst_b)
        take && i_op == OP_ROTATE_RIGHT_BYTE && !i_reg_wr |=>
            o_mem_wdata == {$past(i_mem_data[0]), $past(i_mem_data[7:1])} && $stable(o_status);
    endproperty
    a_rr: assert property (p_rr) else $error("plain rotate right wrong"); // RULE3

    property p_rrc;
        @(posedge i_clk) disable iff (!i_rst_b)
        take && i_op == OP_ROTATE_RIGHT_THRU_CARRY_TO_ACC |=>
            o_acc == {$past(o_status[ST_CARRY]), $past(i_mem_data[7:1])} &&
            o_status[ST_CARRY] == $past(i_mem_data[0]);
    endproperty
    a_rrc: assert property (p_rrc) else $error("rotate right thru carry wrong"); // RULE4

    property p_sbc;
        @(posedge i_clk) disable iff (!i_rst_b)
        take && i_op == OP_SUBTRACT_BORROW_TO_ACC |=>
            o_acc == DATA_W'($past(o_acc) - $past(i_mem_data) - {7'h00, !$past(c_in)});
    endproperty
    a_sbc: assert property (p_sbc) else $error("subtract with carry wrong"); // RULE5

    property p_subm;
        @(posedge i_clk) disable iff (!i_rst_b)
        take && i_op == OP_SUBTRACT_TO_MEM |=> o_mem_we &&
            o_mem_wdata == DATA_W'($past(o_acc) - $past(i_mem_data)) &&
            o_status[ST_CARRY] == ($past(o_acc) >= $past(i_mem_data));
    endproperty
    a_subm: assert property (p_subm) else $error("subtract to memory wrong"); // RULE7 RULE8

    property p_sdz;
        @(posedge i_clk) disable iff (!i_rst_b)
        take && i_op == OP_DECREMENT_SKIP_ZERO |=> o_mem_we &&
            o_mem_wdata == DATA_W'($past(i_mem_data) - ONE) &&
            o_skip == ($past(i_mem_data) == ONE);
    endproperty
    a_sdz: assert property (p_sdz) else $error("decrement skip wrong"); // RULE10

    property p_siza;
        @(posedge i_clk) disable iff (!i_rst_b)
        take && i_op == OP_INCREMENT_SKIP_ZERO_TO_ACC |=> !o_mem_we &&
            o_acc == DATA_W'($past(i_mem_data) + ONE) && o_skip == (o_acc == ZERO);
    endproperty
    a_siza: assert property (p_siza) else $error("increment skip to acc wrong"); // RULE11 RULE12

    property p_dummy;
        @(posedge i_clk) disable iff (!i_rst_b)
        o_skip |=> o_dummy_cycle ##1 !o_dummy_cycle;
    endproperty
    a_dummy: assert property (p_dummy) else $error("dummy cycle missing"); // RULE13

    property p_snz;
        @(posedge i_clk) disable iff (!i_rst_b)
        take && i_op == OP_SKIP_NONZERO_BIT |=>
            o_skip == $past(i_mem_data[i_bit_sel]) && !o_mem_we;
    endproperty
    a_snz: assert property (p_snz) else $error("bit skip if nonzero wrong"); // RULE15

    property p_setb;
        @(posedge i_clk) disable iff (!i_rst_b)
        take && i_op == OP_SET_BIT && !i_reg_wr |=> o_mem_we && $stable(o_status) &&
            o_mem_wdata == ($past(i_mem_data) | DATA_W'(ONE << $past(i_bit_sel)));
    endproperty
    a_setb: assert property (p_setb) else $error("set bit wrong"); // RULE17 RULE9

    property p_sub;
        @(posedge i_clk) disable iff (!i_rst_b)
        take && i_op == OP_SUBTRACT_TO_ACC |=> !o_mem_we &&
            o_acc == DATA_W'($past(o_acc) - $past(i_mem_data)) &&
            o_status[ST_CARRY] == ($past(o_acc) >= $past(i_mem_data));
    endproperty
    a_sub: assert property (p_sub) else $error("subtract to acc wrong"); // RULE6 RULE8

    property p_snzb;
        @(posedge i_clk) disable iff (!i_rst_b)
        take && i_op == OP_SKIP_NONZERO |=>
            o_skip == ($past(i_mem_data) != ZERO) && !o_mem_we;
    endproperty
    a_snzb: assert property (p_snzb) else $error("byte skip if nonzero wrong"); // RULE14

    property p_set;
        @(posedge i_clk) disable iff (!i_rst_b)
        take && i_op == OP_SET_ALL_BITS && !i_reg_wr |=> o_mem_we &&
            o_mem_wdata == ALL_ONES && $stable(o_status);
    endproperty
    a_set: assert property (p_set) else $error("set byte wrong"); // RULE16 RULE9

    property p_rlca;
        @(posedge i_clk) disable iff (!i_rst_b)
        take && i_op == OP_ROTATE_LEFT_THRU_CARRY_TO_ACC |=> !o_mem_we &&
            o_acc == {$past(i_mem_data[6:0]), $past(o_status[ST_CARRY])} &&
            o_status[ST_CARRY] == $past(i_mem_data[7]);
    endproperty
    a_rlca: assert property (p_rlca) else $error("rotate left to acc wrong"); // RULE19 RULE2

    property p_addr;
        @(posedge i_clk) disable iff (!i_rst_b)
        take |=> o_mem_addr == $past(i_mem_addr);
    endproperty
    a_addr: assert property (p_addr) else $error("memory address not passed on"); // RULE18

endmodule : ers_datapath

// >>> ers_pkg.sv
package ers_pkg;

    // ****************************************************************
    // widths
    // ****************************************************************
    localparam int DATA_W = 8;
    localparam int ADDR_W = 16;    // flat data-memory address, any section
    localparam int BIT_W  = 3;
    localparam int RADR_W = 4;

    // ****************************************************************
    // register indexes on the plain register port
    // ****************************************************************
    localparam logic [RADR_W-1:0] REG_ACC    = 4'h0;
    localparam logic [RADR_W-1:0] REG_STATUS = 4'h1;

    // ****************************************************************
    // status bit positions and reset values
    // ****************************************************************
    localparam int ST_CARRY            = 0;
    localparam int ST_NIBBLE_CARRY     = 1;
    localparam int ST_ZERO             = 2;
    localparam int ST_SIGNED_WRAP_BIT  = 3;
    localparam int ST_SIGNED_RESULT    = 4;
    localparam int ST_CHAINED_NULL_BIT = 5;
    localparam int ST_W                = 6;
    localparam logic [ST_W-1:0]   STATUS_RST = 6'h00;
    localparam logic [DATA_W-1:0] ACC_RST    = 8'h00;
    localparam logic [DATA_W-1:0] ALL_ONES   = 8'hff;
    localparam logic [DATA_W-1:0] ONE        = 8'h01;
    localparam logic [DATA_W-1:0] ZERO       = 8'h00;

    // ****************************************************************
    // operations issued by the instruction decoder
    // ****************************************************************
    typedef enum logic [4:0] {
        OP_NONE                           = 5'h00,
        OP_ROTATE_LEFT_THRU_CARRY         = 5'h01,
        OP_ROTATE_LEFT_THRU_CARRY_TO_ACC  = 5'h02,
        OP_ROTATE_RIGHT_BYTE              = 5'h03,
        OP_ROTATE_RIGHT_TO_ACC            = 5'h04,
        OP_ROTATE_RIGHT_THRU_CARRY        = 5'h05,
        OP_ROTATE_RIGHT_THRU_CARRY_TO_ACC = 5'h06,
        OP_SUBTRACT_BORROW_TO_ACC         = 5'h07,
        OP_SUBTRACT_BORROW_TO_MEM         = 5'h08,
        OP_SUBTRACT_TO_ACC                = 5'h09,
        OP_SUBTRACT_TO_MEM                = 5'h0a,
        OP_DECREMENT_SKIP_ZERO            = 5'h0b,
        OP_DECREMENT_SKIP_ZERO_TO_ACC     = 5'h0c,
        OP_INCREMENT_SKIP_ZERO            = 5'h0d,
        OP_INCREMENT_SKIP_ZERO_TO_ACC     = 5'h0e,
        OP_SKIP_NONZERO                   = 5'h0f,
        OP_SKIP_NONZERO_BIT               = 5'h10,
        OP_SET_ALL_BITS                   = 5'h11,
        OP_SET_BIT                        = 5'h12
    } ers_op_e;

endpackage : ers_pkg

// >>> tb_ers_datapath.sv
`timescale 1ns/10ps
module tb_ers_datapath;
    import ers_pkg::*;

    localparam int LIMIT = 6000;

    logic                i_clk;
    logic                i_rst_b;
    logic                i_op_valid;
    ers_op_e             i_op;
    logic [ADDR_W-1:0]   i_mem_addr;
    logic [DATA_W-1:0]   i_mem_data;
    logic [BIT_W-1:0]    i_bit_sel;
    logic [RADR_W-1:0]   i_reg_addr;
    logic [DATA_W-1:0]   i_reg_wdata;
    logic                i_reg_wr;
    logic                i_reg_rd;
    logic [DATA_W-1:0]   o_reg_rdata;
    logic                o_mem_we;
    logic [ADDR_W-1:0]   o_mem_addr;
    logic [DATA_W-1:0]   o_mem_wdata;
    logic [DATA_W-1:0]   o_acc;
    logic [ST_W-1:0]     o_status;
    logic                o_skip;
    logic                o_dummy_cycle;
    int                  err_count;
    int                  n_tests;
    int                  cyc;
    logic [31:0]         seed;
    logic [7:0]          m_acc;
    logic [5:0]          m_st;
    logic [7:0]          pat [4];

    ers_datapath dut_u (
        .i_clk(i_clk), .i_rst_b(i_rst_b), .i_op_valid(i_op_valid), .i_op(i_op),
        .i_mem_addr(i_mem_addr), .i_mem_data(i_mem_data), .i_bit_sel(i_bit_sel),
        .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr),
        .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata), .o_mem_we(o_mem_we),
        .o_mem_addr(o_mem_addr), .o_mem_wdata(o_mem_wdata), .o_acc(o_acc),
        .o_status(o_status), .o_skip(o_skip), .o_dummy_cycle(o_dummy_cycle)
    );

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return s[0] ? ((s >> 1) ^ 32'h80200003) : (s >> 1);
    endfunction : lfsr

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : give_verdict

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    // register port: one-cycle strobes, read data one cycle later
    task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_reg_wr    <= 1'b1;
        i_reg_addr  <= a;
        i_reg_wdata <= d;
        @(posedge i_clk);
        i_reg_wr    <= 1'b0;
        if (a == REG_ACC) m_acc = d;
        else if (a == REG_STATUS) m_st = d[5:0];
    endtask : reg_wr

    task automatic reg_rd(input logic [3:0] a);
        logic [7:0] e;
        e = (a == REG_ACC) ? m_acc : (a == REG_STATUS) ? {2'b00, m_st} : 8'h00;
        @(posedge i_clk);
        i_reg_rd   <= 1'b1;
        i_reg_addr <= a;
        @(posedge i_clk);
        i_reg_rd   <= 1'b0;
        #1;
        check("reg_rdata", o_reg_rdata, e);
        @(posedge i_clk);
        #1;
        check("reg_rdata_idle", o_reg_rdata, 8'h00);
    endtask : reg_rd

    // one op through the model and the design; dst 1 memory, 2 accumulator
    task automatic do_op(input ers_op_e op, input logic [7:0] d, input logic [2:0] b,
                         input logic [15:0] a);
        int dif, nib, dst, bw;
        logic [7:0] r;
        logic [5:0] ns;
        logic sk, ov, wc;
        dst = 0; r = 8'h00; ns = m_st; sk = 1'b0;
        wc = (op == OP_SUBTRACT_BORROW_TO_ACC) || (op == OP_SUBTRACT_BORROW_TO_MEM);
        bw = wc ? int'(!m_st[ST_CARRY]) : 0;
        @(posedge i_clk);
        i_op_valid <= 1'b1;
        i_op       <= op;
        i_mem_data <= d;
        i_bit_sel  <= b;
        i_mem_addr <= a;
        @(posedge i_clk);
        i_op_valid <= 1'b0;
        case (op)
            OP_ROTATE_LEFT_THRU_CARRY, OP_ROTATE_LEFT_THRU_CARRY_TO_ACC: begin
                r = {d[6:0], m_st[ST_CARRY]};
                ns[ST_CARRY] = d[7];
                dst = (op == OP_ROTATE_LEFT_THRU_CARRY) ? 1 : 2;
            end
            OP_ROTATE_RIGHT_BYTE, OP_ROTATE_RIGHT_TO_ACC: begin
                r = {d[0], d[7:1]};
                dst = (op == OP_ROTATE_RIGHT_BYTE) ? 1 : 2;
            end
            OP_ROTATE_RIGHT_THRU_CARRY, OP_ROTATE_RIGHT_THRU_CARRY_TO_ACC: begin
                r = {m_st[ST_CARRY], d[7:1]};
                ns[ST_CARRY] = d[0];
                dst = (op == OP_ROTATE_RIGHT_THRU_CARRY) ? 1 : 2;
            end
            OP_SUBTRACT_BORROW_TO_ACC, OP_SUBTRACT_BORROW_TO_MEM,
            OP_SUBTRACT_TO_ACC, OP_SUBTRACT_TO_MEM: begin
                dif = int'(m_acc) - int'(d) - bw;
                nib = int'(m_acc[3:0]) - int'(d[3:0]) - bw;
                r = dif[7:0];
                ov = (m_acc[7] != d[7]) && (r[7] != m_acc[7]);
                ns = {wc ? ((r == 8'h00) && m_st[ST_CHAINED_NULL_BIT]) : (r == 8'h00),
                      ov ^ r[7], ov, r == 8'h00, nib >= 0, dif >= 0};
                dst = (op == OP_SUBTRACT_BORROW_TO_MEM || op == OP_SUBTRACT_TO_MEM) ? 1 : 2;
            end
            OP_DECREMENT_SKIP_ZERO, OP_DECREMENT_SKIP_ZERO_TO_ACC: begin
                r = d - 8'h01;
                sk = (r == 8'h00);
                dst = (op == OP_DECREMENT_SKIP_ZERO) ? 1 : 2;
            end
            OP_INCREMENT_SKIP_ZERO, OP_INCREMENT_SKIP_ZERO_TO_ACC: begin
                r = d + 8'h01;
                sk = (r == 8'h00);
                dst = (op == OP_INCREMENT_SKIP_ZERO) ? 1 : 2;
            end
            OP_SKIP_NONZERO: sk = (d != 8'h00);
            OP_SKIP_NONZERO_BIT: sk = d[b];
            OP_SET_ALL_BITS: begin
                r = 8'hff;
                dst = 1;
            end
            OP_SET_BIT: begin
                r = d;
                r[b] = 1'b1;
                dst = 1;
            end
            default: ;
        endcase
        #1;
        check("mem_we", o_mem_we, dst == 1);
        if (dst == 1) begin
            check("mem_wdata", o_mem_wdata, r);
            check("mem_addr", o_mem_addr, a);
        end
        if (dst == 2) m_acc = r;
        m_st = ns;
        check("acc", o_acc, m_acc);
        check("status", o_status, m_st);
        check("skip", o_skip, sk);
        check("dummy", o_dummy_cycle, 1'b0);
        if (sk) begin
            // an op offered in the dummy cycle must be ignored
            @(posedge i_clk);
            i_op_valid <= 1'b1;
            i_op       <= OP_SET_ALL_BITS;
            #1;
            check("dummy", o_dummy_cycle, 1'b1);
            check("skip", o_skip, 1'b0);
            @(posedge i_clk);
            i_op_valid <= 1'b0;
            #1;
            check("mem_we", o_mem_we, 1'b0);
            check("dummy", o_dummy_cycle, 1'b0);
        end
    endtask : do_op

    // ****************************************************************
    // clock, timeout and main sequence
    // ****************************************************************
    initial begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end

    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            err_count++;
            $display("mismatch timeout expected done seen hang");
            give_verdict();
        end
    end

    initial begin
        err_count = 0; n_tests = 0; seed = 32'h00014dee;
        m_acc = ACC_RST; m_st = STATUS_RST;
        pat = '{8'h01, 8'hff, 8'h80, 8'h00};
        i_rst_b = 1'b0; i_op_valid = 1'b0; i_op = OP_NONE; i_mem_addr = 16'h0000;
        i_mem_data = 8'h00; i_bit_sel = 3'h0; i_reg_addr = 4'h0; i_reg_wdata = 8'h00;
        i_reg_wr = 1'b0; i_reg_rd = 1'b0;
        repeat (20) @(posedge i_clk);
        i_rst_b <= 1'b1;
        @(posedge i_clk);
        #1;
        check("reset_out", {o_acc, o_status, o_skip, o_mem_we, o_dummy_cycle}, 32'h0);
        // register port incl. unmapped index
        reg_wr(REG_ACC, 8'h5a);
        reg_wr(REG_STATUS, 8'hff);
        reg_wr(4'h7, 8'h33);
        reg_rd(REG_ACC);
        reg_rd(REG_STATUS);
        reg_rd(4'h7);
        $display("test registers done");
        // every op on boundary bytes, carry toggled between passes
        for (int p = 0; p < 4; p++) begin
            for (int k = 1; k <= 18; k++) begin
                reg_wr(REG_STATUS, (p % 2 == 1) ? 8'h21 : 8'h00);
                reg_wr(REG_ACC, pat[(p + k) % 4]);
                do_op(ers_op_e'(k), pat[p], 3'(k), 16'(k * 16'h1111));
            end
        end
        $display("test every_op done");
        // random ops, at least one idle cycle apart, with random operands
        for (int i = 0; i < 80; i++) begin
            seed = lfsr(seed);
            if (seed[31:29] == 3'h0) reg_wr(REG_ACC, seed[23:16]);
            do_op(ers_op_e'(1 + int'(seed[4:0]) % 18), seed[12:5], seed[15:13], seed[31:16]);
        end
        reg_rd(REG_STATUS);
        $display("test random done");
        give_verdict();
    end
endmodule : tb_ers_datapath
